// *** src/pss_pkg.sv ***
package pss_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned SUM_W  = 16;
    localparam int unsigned IRQ_W  = 5;

    // Byte addresses of the word-aligned registers.
    localparam logic [7:0] OFF_SUMMARY    = 8'h00;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h08;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0C;

    localparam logic [SUM_W-1:0] SUMMARY_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET     = 5'h00;

    // Field positions of the status summary register.
    localparam int unsigned BIT_RX_ERR    = 13;
    localparam int unsigned BIT_POLARITY  = 12;
    localparam int unsigned BIT_FALSE_CAR = 11;
    localparam int unsigned BIT_SIG_DET   = 10;
    localparam int unsigned BIT_DESC_LOCK = 9;
    localparam int unsigned BIT_PAGE_RX   = 8;
    localparam int unsigned BIT_INT_PEND  = 7;
    localparam int unsigned BIT_REM_FAULT = 6;
    localparam int unsigned BIT_JABBER    = 5;
    localparam int unsigned BIT_AN_DONE   = 4;
    localparam int unsigned BIT_LOOPBACK  = 3;
    localparam int unsigned BIT_DUPLEX    = 2;
    localparam int unsigned BIT_SPEED10   = 1;
    localparam int unsigned BIT_LINK      = 0;

    // Field positions of the interrupt status, clear and enable registers.
    localparam int unsigned IRQ_RX_ERR    = 0;
    localparam int unsigned IRQ_FALSE_CAR = 1;
    localparam int unsigned IRQ_REM_FAULT = 2;
    localparam int unsigned IRQ_PAGE_RX   = 3;
    localparam int unsigned IRQ_INT_PEND  = 4;

endpackage : pss_pkg

// *** src/pss_status.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - Bits 15:14 always read zero; writes to them are ignored.
// - Receive-error latch sets on an error, clears only on error-counter read.
// - Polarity bit copies the 10BASE-T status bit; cleared by that register's read.
// - False-carrier latch sets on an event, clears only on counter read.
// - Signal-detect bit latches low and resets to zero.
// - Descrambler-lock bit latches low and resets to zero.
// - Page-received copies expansion flag; cleared by expansion read only.
// - Interrupt-pending latches high and clears on the read returning it.
// - Remote fault sets from partner, cleared by basic status read or reset.
// - Jabber copies the basic status jabber bit; summary read keeps it.
// - Auto-negotiation complete reads one once negotiation finished.
// - Loopback bit reads one while loopback is enabled.
// - Duplex bit from negotiation or forced mode, one is full duplex.
// - Speed bit from negotiation or forced mode, one is 10 Mb/s.
// - Link bit copies basic status link; summary read does not clear it.
// - Summary register is 16 bits and reads zero after hard reset.
module pss_status #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [ADDR_W-1:0]           paddr_i,
    input  wire logic [pss_pkg::DATA_W-1:0]  pwdata_i,
    output logic      [pss_pkg::DATA_W-1:0]  prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    input  wire logic                        rx_error_event_i,
    input  wire logic                        receive_error_counter_read_i,
    input  wire logic                        polarity_inverted_i,
    input  wire logic                        ten_base_t_status_read_i,
    input  wire logic                        false_carrier_event_i,
    input  wire logic                        false_carrier_counter_read_i,
    input  wire logic                        signal_detect_i,
    input  wire logic                        descrambler_lock_i,
    input  wire logic                        page_received_i,
    input  wire logic                        autoneg_expansion_read_i,
    input  wire logic                        phy_int_pending_i,
    input  wire logic                        remote_fault_i,
    input  wire logic                        basic_mode_status_read_i,
    input  wire logic                        jabber_i,
    input  wire logic                        an_complete_i,
    input  wire logic                        loopback_i,
    input  wire logic                        full_duplex_i,
    input  wire logic                        speed10_i,
    input  wire logic                        link_i,
    output logic                             irq_o
);

    logic [pss_pkg::SUM_W-1:0] summary;
    logic [pss_pkg::SUM_W-1:0] next_summary;
    logic [pss_pkg::IRQ_W-1:0] irq_status;
    logic [pss_pkg::IRQ_W-1:0] irq_enable;
    logic [pss_pkg::IRQ_W-1:0] irq_events;
    logic [7:0]                addr;
    logic                      setup;
    logic                      sum_read;
    logic                      wr_done;
    logic                      mapped;

    assign addr    = 8'(paddr_i);
    // Read side effects happen at the setup edge, the same edge that captures
    // prdata, so no event can slip between the sample and the clear.
    assign setup    = psel_i & ~penable_i;
    assign sum_read = setup & ~pwrite_i & (addr == pss_pkg::OFF_SUMMARY);
    assign wr_done  = psel_i & penable_i & pwrite_i;
    assign mapped   = (addr == pss_pkg::OFF_SUMMARY) | (addr == pss_pkg::OFF_IRQ_STATUS)
                    | (addr == pss_pkg::OFF_IRQ_CLEAR) | (addr == pss_pkg::OFF_IRQ_ENABLE);

    // One wait-free access phase: data was registered during setup.
    assign pready_o = 1'b1;

    always_comb begin
        next_summary = summary;
        next_summary[15:14] = 2'h0;
        // Latched-high flags: a set in the clearing cycle wins.
        if (receive_error_counter_read_i) begin
            next_summary[pss_pkg::BIT_RX_ERR] = 1'b0;
        end
        if (rx_error_event_i) begin
            next_summary[pss_pkg::BIT_RX_ERR] = 1'b1;
        end
        if (ten_base_t_status_read_i) begin
            next_summary[pss_pkg::BIT_POLARITY] = 1'b0;
        end
        if (polarity_inverted_i) begin
            next_summary[pss_pkg::BIT_POLARITY] = 1'b1;
        end
        if (false_carrier_counter_read_i) begin
            next_summary[pss_pkg::BIT_FALSE_CAR] = 1'b0;
        end
        if (false_carrier_event_i) begin
            next_summary[pss_pkg::BIT_FALSE_CAR] = 1'b1;
        end
        // Latched-low flags re-arm to the live level once software has read them.
        if (sum_read) begin
            next_summary[pss_pkg::BIT_SIG_DET]   = signal_detect_i;
            next_summary[pss_pkg::BIT_DESC_LOCK] = descrambler_lock_i;
        end else begin
            next_summary[pss_pkg::BIT_SIG_DET]   = summary[pss_pkg::BIT_SIG_DET] & signal_detect_i;
            next_summary[pss_pkg::BIT_DESC_LOCK] = summary[pss_pkg::BIT_DESC_LOCK]
                                                 & descrambler_lock_i;
        end
        if (autoneg_expansion_read_i) begin
            next_summary[pss_pkg::BIT_PAGE_RX] = 1'b0;
        end
        if (page_received_i) begin
            next_summary[pss_pkg::BIT_PAGE_RX] = 1'b1;
        end
        if (sum_read) begin
            next_summary[pss_pkg::BIT_INT_PEND] = 1'b0;
        end
        if (phy_int_pending_i) begin
            next_summary[pss_pkg::BIT_INT_PEND] = 1'b1;
        end
        if (basic_mode_status_read_i) begin
            next_summary[pss_pkg::BIT_REM_FAULT] = 1'b0;
        end
        if (remote_fault_i) begin
            next_summary[pss_pkg::BIT_REM_FAULT] = 1'b1;
        end
        next_summary[pss_pkg::BIT_JABBER]  = jabber_i;
        next_summary[pss_pkg::BIT_AN_DONE] = an_complete_i;
        next_summary[pss_pkg::BIT_LOOPBACK] = loopback_i;
        next_summary[pss_pkg::BIT_DUPLEX]  = full_duplex_i;
        next_summary[pss_pkg::BIT_SPEED10] = speed10_i;
        next_summary[pss_pkg::BIT_LINK]    = link_i;
    end

    // Bus writes never reach this register, so software writes cannot disturb it.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            summary <= pss_pkg::SUMMARY_RESET;
        end else begin
            summary <= next_summary;
        end
    end

    // A latched-high flag other than polarity becoming set is an interrupt event.
    assign irq_events = {
        next_summary[pss_pkg::BIT_INT_PEND]  & ~summary[pss_pkg::BIT_INT_PEND],
        next_summary[pss_pkg::BIT_PAGE_RX]   & ~summary[pss_pkg::BIT_PAGE_RX],
        next_summary[pss_pkg::BIT_REM_FAULT] & ~summary[pss_pkg::BIT_REM_FAULT],
        next_summary[pss_pkg::BIT_FALSE_CAR] & ~summary[pss_pkg::BIT_FALSE_CAR],
        next_summary[pss_pkg::BIT_RX_ERR]    & ~summary[pss_pkg::BIT_RX_ERR]
    };

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status <= pss_pkg::IRQ_RESET;
        end else begin
            if (wr_done && addr == pss_pkg::OFF_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~pwdata_i[pss_pkg::IRQ_W-1:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_enable <= pss_pkg::IRQ_RESET;
        end else if (wr_done && addr == pss_pkg::OFF_IRQ_ENABLE) begin
            irq_enable <= pwdata_i[pss_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            pslverr_o <= ~mapped;
            prdata_o  <= '0;
            if (!pwrite_i) begin
                unique case (1'b1)
                    addr == pss_pkg::OFF_SUMMARY:    prdata_o <= 32'(summary);
                    addr == pss_pkg::OFF_IRQ_STATUS: prdata_o <= 32'(irq_status);
                    addr == pss_pkg::OFF_IRQ_ENABLE: prdata_o <= 32'(irq_enable);
                    default:                         prdata_o <= '0;
                endcase
            end
        end
    end

    a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[15:14] == 2'h0)
        else $error("reserved summary bits not zero");

    a_rxerr_latch: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_RX_ERR] && !receive_error_counter_read_i && !rx_error_event_i
        |=> summary[pss_pkg::BIT_RX_ERR] ##0 $stable(summary[pss_pkg::BIT_RX_ERR]))
        else $error("receive error latch lost");

    a_rxerr_set: assert property (@(posedge clock_i) disable iff (rst_i)
        rx_error_event_i |=> summary[pss_pkg::BIT_RX_ERR])
        else $error("receive error latch not set");

    a_polarity_copy: assert property (@(posedge clock_i) disable iff (rst_i)
        polarity_inverted_i ##1 (sum_read && !ten_base_t_status_read_i)
        |=> summary[pss_pkg::BIT_POLARITY])
        else $error("polarity cleared by summary read");

    a_false_carrier: assert property (@(posedge clock_i) disable iff (rst_i)
        false_carrier_event_i ##1 !false_carrier_counter_read_i [*2]
        |=> summary[pss_pkg::BIT_FALSE_CAR])
        else $error("false carrier latch lost");

    a_sigdet_low: assert property (@(posedge clock_i) disable iff (rst_i)
        !signal_detect_i ##1 !sum_read |=> !summary[pss_pkg::BIT_SIG_DET])
        else $error("signal detect low not latched");

    a_lock_low: assert property (@(posedge clock_i) disable iff (rst_i)
        !descrambler_lock_i ##1 !sum_read |=> !summary[pss_pkg::BIT_DESC_LOCK])
        else $error("descrambler lock low not latched");

    a_page_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        page_received_i ##1 !autoneg_expansion_read_i |=> summary[pss_pkg::BIT_PAGE_RX])
        else $error("page received lost");

    a_int_cor: assert property (@(posedge clock_i) disable iff (rst_i)
        sum_read && !phy_int_pending_i |=> !summary[pss_pkg::BIT_INT_PEND])
        else $error("interrupt pending not cleared by read");

    a_rfault_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        basic_mode_status_read_i && !remote_fault_i |=> !summary[pss_pkg::BIT_REM_FAULT])
        else $error("remote fault not cleared");

    a_mirror_bits: assert property (@(posedge clock_i) disable iff (rst_i)
        1'b1 |=> summary[5:0] == $past({jabber_i, an_complete_i, loopback_i,
                                        full_duplex_i, speed10_i, link_i}))
        else $error("mirrored status bits wrong");

    // Flag behaviour around the clearing reads: a set always wins, and a read that
    // belongs to another register never disturbs a flag it does not own.
    a_rxerr_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        receive_error_counter_read_i && !rx_error_event_i
        |=> !summary[pss_pkg::BIT_RX_ERR])
        else $error("receive error latch not cleared");

    a_rxerr_keep: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_RX_ERR] && sum_read && !receive_error_counter_read_i
        |=> summary[pss_pkg::BIT_RX_ERR])
        else $error("receive error latch cleared by summary read");

    a_polarity_set: assert property (@(posedge clock_i) disable iff (rst_i)
        polarity_inverted_i |=> summary[pss_pkg::BIT_POLARITY])
        else $error("polarity bit not set");

    a_polarity_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        ten_base_t_status_read_i && !polarity_inverted_i
        |=> !summary[pss_pkg::BIT_POLARITY])
        else $error("polarity bit not cleared");

    a_fcar_set: assert property (@(posedge clock_i) disable iff (rst_i)
        false_carrier_event_i |=> summary[pss_pkg::BIT_FALSE_CAR])
        else $error("false carrier latch not set");

    a_fcar_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        false_carrier_counter_read_i && !false_carrier_event_i
        |=> !summary[pss_pkg::BIT_FALSE_CAR])
        else $error("false carrier latch not cleared");

    a_fcar_keep: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_FALSE_CAR] && sum_read && !false_carrier_counter_read_i
        |=> summary[pss_pkg::BIT_FALSE_CAR])
        else $error("false carrier latch cleared by summary read");

    a_sigdet_rearm: assert property (@(posedge clock_i) disable iff (rst_i)
        sum_read |=> summary[pss_pkg::BIT_SIG_DET] == $past(signal_detect_i))
        else $error("signal detect not re-armed by read");

    a_lock_rearm: assert property (@(posedge clock_i) disable iff (rst_i)
        sum_read |=> summary[pss_pkg::BIT_DESC_LOCK] == $past(descrambler_lock_i))
        else $error("descrambler lock not re-armed by read");

    a_sigdet_stay: assert property (@(posedge clock_i) disable iff (rst_i)
        !summary[pss_pkg::BIT_SIG_DET] && !sum_read
        |=> !summary[pss_pkg::BIT_SIG_DET])
        else $error("signal detect rose without a read");

    a_lock_stay: assert property (@(posedge clock_i) disable iff (rst_i)
        !summary[pss_pkg::BIT_DESC_LOCK] && !sum_read
        |=> !summary[pss_pkg::BIT_DESC_LOCK])
        else $error("descrambler lock rose without a read");

    a_page_set: assert property (@(posedge clock_i) disable iff (rst_i)
        page_received_i |=> summary[pss_pkg::BIT_PAGE_RX])
        else $error("page received not set");

    a_page_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        autoneg_expansion_read_i && !page_received_i
        |=> !summary[pss_pkg::BIT_PAGE_RX])
        else $error("page received not cleared");

    a_page_keep: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_PAGE_RX] && sum_read && !autoneg_expansion_read_i
        |=> summary[pss_pkg::BIT_PAGE_RX])
        else $error("page received cleared by summary read");

    a_int_set: assert property (@(posedge clock_i) disable iff (rst_i)
        phy_int_pending_i |=> summary[pss_pkg::BIT_INT_PEND])
        else $error("interrupt pending not set");

    a_int_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_INT_PEND] && !sum_read
        |=> summary[pss_pkg::BIT_INT_PEND])
        else $error("interrupt pending lost without a read");

    a_int_returned: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_INT_PEND] && sum_read
        |=> prdata_o[pss_pkg::BIT_INT_PEND])
        else $error("clearing read did not return interrupt pending");

    a_rfault_set: assert property (@(posedge clock_i) disable iff (rst_i)
        remote_fault_i |=> summary[pss_pkg::BIT_REM_FAULT])
        else $error("remote fault not set");

    a_rfault_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        summary[pss_pkg::BIT_REM_FAULT] && !basic_mode_status_read_i
        |=> summary[pss_pkg::BIT_REM_FAULT])
        else $error("remote fault lost without a clearing read");

    // Bus-side checks: what software sees in the access phase is the register as it
    // stood at the setup edge, before that edge applied the read side effects.
    a_read_data: assert property (@(posedge clock_i) disable iff (rst_i)
        sum_read |=> prdata_o == 32'($past(summary)))
        else $error("summary read data wrong");

    a_upper_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        prdata_o[pss_pkg::DATA_W-1:pss_pkg::SUM_W] == '0)
        else $error("read data above the register width not zero");

    a_write_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
        setup && pwrite_i && addr == pss_pkg::OFF_SUMMARY
        |=> !pslverr_o)
        else $error("summary write flagged as error");

    a_unmapped_err: assert property (@(posedge clock_i) disable iff (rst_i)
        setup && !mapped
        |=> pslverr_o && prdata_o == '0)
        else $error("unmapped access not flagged");

    a_pready_high: assert property (@(posedge clock_i) disable iff (rst_i)
        pready_o)
        else $error("ready dropped");

    // Interrupt checks: status bits stay until a clear write, the output follows them.
    a_irq_level: assert property (@(posedge clock_i) disable iff (rst_i)
        1'b1
        |=> irq_o == |($past(irq_status) & $past(irq_enable)))
        else $error("interrupt output does not follow enabled status");

    a_irq_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
        !(wr_done && addr == pss_pkg::OFF_IRQ_CLEAR)
        |=> (irq_status & $past(irq_status)) == $past(irq_status))
        else $error("interrupt status bit lost without a clear");

endmodule : pss_status

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        clock_i     = 1'b0;
    logic        rst_i       = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        er;
    logic [4:0]  ev          = 5'h00;
    logic [4:0]  clr         = 5'h00;
    logic [5:0]  lv          = 6'h00;
    logic [5:0]  nv;
    logic        sd          = 1'b0;
    logic        dl          = 1'b0;
    logic        ip          = 1'b0;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          pos [5]     = '{13, 11, 6, 8, 12};

    pss_status u_pss_status (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .rx_error_event_i(ev[0]), .receive_error_counter_read_i(clr[0]),
        .false_carrier_event_i(ev[1]), .false_carrier_counter_read_i(clr[1]),
        .remote_fault_i(ev[2]), .basic_mode_status_read_i(clr[2]),
        .page_received_i(ev[3]), .autoneg_expansion_read_i(clr[3]),
        .polarity_inverted_i(ev[4]), .ten_base_t_status_read_i(clr[4]),
        .signal_detect_i(sd), .descrambler_lock_i(dl), .phy_int_pending_i(ip),
        .jabber_i(lv[5]), .an_complete_i(lv[4]), .loopback_i(lv[3]),
        .full_duplex_i(lv[2]), .speed10_i(lv[1]), .link_i(lv[0]), .irq_o(irq)
    );

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    task results;
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // The whole run needs under four hundred cycles; twenty thousand means a hang.
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdsum(input logic [31:0] exp);
        apb(1'b0, pss_pkg::OFF_SUMMARY, 32'h0);
        chk("summary", rd, exp);
    endtask : rdsum

    task pulse(input logic [4:0] e, input logic [4:0] c);
        @(posedge clock_i);
        ev  <= e;
        clr <= c;
        @(posedge clock_i);
        ev  <= 5'h00;
        clr <= 5'h00;
    endtask : pulse

    task settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : settle

    function automatic logic [31:0] mirror(input logic [5:0] l);
        return {26'h0, l};
    endfunction : mirror

    initial begin
        void'($urandom(32'hB612));
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        rdsum(32'h0);
        apb(1'b0, pss_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("irq_status", rd, 32'h0);
        chk("mapped_err", {31'h0, er}, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'b1, pss_pkg::OFF_IRQ_ENABLE, 32'h1);
        pulse(5'h02, 5'h00);
        settle(4);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        pulse(5'h01, 5'h00);
        settle(4);
        chk("irq_raised", {31'h0, irq}, 32'h1);
        apb(1'b1, pss_pkg::OFF_IRQ_CLEAR, 32'h1);
        settle(2);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        apb(1'b1, pss_pkg::OFF_IRQ_STATUS, 32'h0);
        apb(1'b0, pss_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("irq_status", rd, 32'h2);
        apb(1'b1, pss_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
        apb(1'b0, pss_pkg::OFF_IRQ_ENABLE, 32'h0);
        chk("irq_enable", rd, 32'h1F);
        apb(1'b1, pss_pkg::OFF_IRQ_CLEAR, 32'h1F);
        pulse(5'h00, 5'h1F);
        settle(2);
        chk("irq_all_clear", {31'h0, irq}, 32'h0);
        rdsum(32'h0);
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i, 5'h00);
            rdsum(32'h1 << pos[i]);
            rdsum(32'h1 << pos[i]);
            apb(1'b1, pss_pkg::OFF_SUMMARY, 32'hFFFF_FFFF);
            rdsum(32'h1 << pos[i]);
            pulse(5'h00, 5'h01 << i);
            rdsum(32'h0);
        end
        apb(1'b1, pss_pkg::OFF_IRQ_CLEAR, 32'h1F);
        @(posedge clock_i);
        ip <= 1'b1;
        @(posedge clock_i);
        ip <= 1'b0;
        rdsum(32'h80);
        rdsum(32'h0);
        @(posedge clock_i);
        sd <= 1'b1;
        dl <= 1'b1;
        rdsum(32'h0);
        rdsum(32'h600);
        // A one-cycle dip must survive until the next summary read.
        for (int j = 0; j < 2; j++) begin
            @(posedge clock_i);
            sd <= (j == 1);
            dl <= (j == 0);
            @(posedge clock_i);
            sd <= 1'b1;
            dl <= 1'b1;
            settle(2);
            rdsum(j == 0 ? 32'h200 : 32'h400);
            rdsum(32'h600);
        end
        @(posedge clock_i);
        sd <= 1'b0;
        dl <= 1'b0;
        rdsum(32'h0);
        rdsum(32'h0);
        for (int k = 0; k < 24; k++) begin
            @(posedge clock_i);
            nv = (k < 2) ? {6{k[0]}} : 6'($urandom());
            lv <= nv;
            rdsum(mirror(nv));
            rdsum(mirror(nv));
            if (nv[0] && nv[4]) begin
                chk("speed_duplex", {30'h0, rd[2:1]}, {30'h0, nv[2:1]});
            end
        end
        // Latch the five event flags (not interrupt pending), then reset mid-run: all of them must fall back to zero.
        lv <= 6'h00;
        pulse(5'h1F, 5'h00);
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        chk("irq_reset", {31'h0, irq}, 32'h0);
        chk("pready", {31'h0, pready}, 32'h1);
        rdsum(32'h0);
        apb(1'b0, pss_pkg::OFF_IRQ_ENABLE, 32'h0);
        chk("irq_enable_reset", rd, 32'h0);
        results();
    end
endmodule : tb
